// ==== rtl/pprc_pkg.sv ====
/*
  Package for the pin remap and change-notice control block: register map,
  field positions, reset values, sizes, the bus request struct and the change-notice struct.
  Assumes a single 100 MHz clock domain and a plain strobe register port.
*/
`default_nettype none
package pprc_pkg;

  localparam int unsigned N_IN    = 8;
  localparam int unsigned N_OUT   = 8;
  localparam int unsigned N_PORT  = 3;
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned SEL_W   = 4;

  // Byte base addresses; each entry is one aligned word, 4 bytes apart.
  localparam logic [ADDR_W-1:0] IN_SEL_BASE  = 8'h00;
  localparam logic [ADDR_W-1:0] OUT_SEL_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] CN_CTRL_BASE = 8'h80;
  localparam logic [ADDR_W-1:0] LOCK_ADDR    = 8'hc0;

  localparam int unsigned SEL_LSB     = 0;
  localparam int unsigned CN_ON_BIT   = 15;
  localparam int unsigned CN_IDLE_BIT = 13;
  localparam int unsigned LOCK_BIT    = 13;

  localparam logic [SEL_W-1:0] SEL_RST = 4'h0;
  localparam logic             BIT_RST = 1'b0;
  localparam logic [31:0]      RD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } pprc_req_t;

  typedef struct packed {
    logic on;
    logic idle_stop;
  } pprc_cn_t;

endpackage : pprc_pkg
`default_nettype wire

// ==== rtl/pprc_remap.sv ====
/*
  Register side of the peripheral pin remap unit and the per-port
  change-notice control. Routing muxes sit here, driven by the stored selectors.
  Assumes pins are synchronous to sys_clk's peripheral logic except pin_in.
*/
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module pprc_remap
  import pprc_pkg::*;
#(
  parameter logic [16*4-1:0] IN_MAP  = 64'hfedc_ba98_7654_3210,
  parameter logic [16*4-1:0] OUT_MAP = 64'hfedc_ba98_7654_3210
)
(
  input  wire logic                     sys_clk,
  input  wire logic                     resetn,
  input  wire pprc_req_t                req,
  output var  logic [31:0]              rdata,
  input  wire logic                     idle_mode,
  input  wire logic [15:0]              pin_in,
  input  wire logic [15:0]              periph_out,
  output var  logic [N_IN-1:0]          periph_in,
  output var  logic [N_OUT-1:0]         pin_out,
  output var  pprc_cn_t [N_PORT-1:0]    cn_active,
  output var  logic                     remap_lock
);

  logic [SEL_W-1:0]    in_sel_r  [N_IN];
  logic [SEL_W-1:0]    in_sel_nxt[N_IN];
  logic [SEL_W-1:0]    out_sel_r [N_OUT];
  logic [SEL_W-1:0]    out_sel_nxt[N_OUT];
  pprc_cn_t            cn_r      [N_PORT];
  pprc_cn_t            cn_nxt    [N_PORT];
  logic                lock_r;
  logic                lock_nxt;
  logic [31:0]         rdata_nxt;
  logic [15:0]         pin_m_r;
  logic [15:0]         pin_s_r;
  logic [N_IN-1:0]     pin_in_nxt;
  logic [N_OUT-1:0]    pin_out_nxt;
  pprc_cn_t [N_PORT-1:0] cn_act_nxt;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base,
                               input int unsigned idx);
    hit = (a == ADDR_W'(base + ADDR_W'(idx * 4)));
  endfunction : hit

  function automatic logic [3:0] lut(input logic [16*4-1:0] map, input logic [SEL_W-1:0] s);
    lut = map[s*4 +: 4];
  endfunction : lut

  // The lock word stands in for the device configuration word and is not itself protected.
  always_comb
  begin
    lock_nxt = lock_r;
    if (req.wr && req.addr == LOCK_ADDR)
    begin
      lock_nxt = req.wdata[LOCK_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lock_r     <= BIT_RST;
      remap_lock <= BIT_RST;
    end
    else
    begin
      lock_r     <= lock_nxt;
      remap_lock <= lock_nxt;
    end
  end

  always_comb
  begin
    for (int i = 0; i < N_IN; i++)
    begin
      in_sel_nxt[i] = in_sel_r[i];
      if (req.wr && !lock_r && hit(req.addr, IN_SEL_BASE, i))
      begin
        in_sel_nxt[i] = req.wdata[SEL_LSB +: SEL_W];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < N_IN; i++) in_sel_r[i] <= SEL_RST;
    end
    else
    begin
      in_sel_r <= in_sel_nxt;
    end
  end

  always_comb
  begin
    for (int i = 0; i < N_OUT; i++)
    begin
      out_sel_nxt[i] = out_sel_r[i];
      if (req.wr && !lock_r && hit(req.addr, OUT_SEL_BASE, i))
      begin
        out_sel_nxt[i] = req.wdata[SEL_LSB +: SEL_W];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < N_OUT; i++) out_sel_r[i] <= SEL_RST;
    end
    else
    begin
      out_sel_r <= out_sel_nxt;
    end
  end

  // The lock guards the routing only, so change-notice control stays writable.
  always_comb
  begin
    for (int p = 0; p < N_PORT; p++)
    begin
      cn_nxt[p] = cn_r[p];
      if (req.wr && hit(req.addr, CN_CTRL_BASE, p))
      begin
        cn_nxt[p].on        = req.wdata[CN_ON_BIT];
        cn_nxt[p].idle_stop = req.wdata[CN_IDLE_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int p = 0; p < N_PORT; p++) cn_r[p] <= '{on: BIT_RST, idle_stop: BIT_RST};
    end
    else
    begin
      cn_r <= cn_nxt;
    end
  end

  // Read data is zero outside the cycle after a read, so unmapped words read zero too.
  always_comb
  begin
    rdata_nxt = RD_ZERO;
    if (req.rd && req.addr == LOCK_ADDR)
    begin
      rdata_nxt[LOCK_BIT] = lock_r;
    end
    for (int i = 0; i < N_IN; i++)
    begin
      if (req.rd && hit(req.addr, IN_SEL_BASE, i))
      begin
        rdata_nxt[SEL_LSB +: SEL_W] = in_sel_r[i];
      end
    end
    for (int i = 0; i < N_OUT; i++)
    begin
      if (req.rd && hit(req.addr, OUT_SEL_BASE, i))
      begin
        rdata_nxt[SEL_LSB +: SEL_W] = out_sel_r[i];
      end
    end
    for (int p = 0; p < N_PORT; p++)
    begin
      if (req.rd && hit(req.addr, CN_CTRL_BASE, p))
      begin
        rdata_nxt[CN_ON_BIT]   = cn_r[p].on;
        rdata_nxt[CN_IDLE_BIT] = cn_r[p].idle_stop;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata <= RD_ZERO;
    end
    else
    begin
      rdata <= rdata_nxt;
    end
  end

  // Pins are synchronised before routing; this costs two cycles of input latency.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_m_r <= '0;
      pin_s_r <= '0;
    end
    else
    begin
      pin_m_r <= pin_in;
      pin_s_r <= pin_m_r;
    end
  end

  always_comb
  begin
    for (int p = 0; p < N_PORT; p++)
    begin
      // Idle only gates activity; the stored enable is left for software to see.
      cn_act_nxt[p].on        = cn_r[p].on && !(cn_r[p].idle_stop && idle_mode);
      cn_act_nxt[p].idle_stop = cn_r[p].idle_stop;
    end
    for (int i = 0; i < N_IN; i++)
    begin
      pin_in_nxt[i] = pin_s_r[lut(IN_MAP, in_sel_r[i])];
    end
    for (int i = 0; i < N_OUT; i++)
    begin
      pin_out_nxt[i] = periph_out[lut(OUT_MAP, out_sel_r[i])];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      periph_in <= '0;
      pin_out   <= '0;
      cn_active <= '0;
    end
    else
    begin
      periph_in <= pin_in_nxt;
      pin_out   <= pin_out_nxt;
      cn_active <= cn_act_nxt;
    end
  end

endmodule : pprc_remap
`default_nettype wire

// ==== test/pprc_remap_bench.sv ====
/* Bench for pprc_remap: strobe accesses and routed outputs.
   Assumes default identity tables and a 100 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module pprc_remap_bench
  import pprc_pkg::*;
;
  logic sys_clk = 1'b0, resetn = 1'b0, idle_mode = 1'b0, ev = 1'b0, v1 = 1'b0, remap_lock;
  logic [15:0] pin_in = 16'h0020, periph_out = 16'h0004;
  logic [31:0] rdata, ed = 32'h0, e1 = 32'h0;
  logic [N_IN-1:0] periph_in;
  logic [N_OUT-1:0] pin_out;
  pprc_cn_t [N_PORT-1:0] cn_active;
  pprc_req_t req = '0;
  int n_errors = 0, total_checks = 0;
  pprc_remap u_pprc_remap (.sys_clk(sys_clk), .resetn(resetn), .req(req), .rdata(rdata),
    .idle_mode(idle_mode), .pin_in(pin_in), .periph_out(periph_out), .periph_in(periph_in),
    .pin_out(pin_out), .cn_active(cn_active), .remap_lock(remap_lock));
  always #5 sys_clk = ~sys_clk;
  // Read data is valid only in the cycle after the strobe, zero elsewhere.
  always @(posedge sys_clk)
  begin
    v1 <= ev;
    e1 <= ed;
  end
  always @(negedge sys_clk) chk("rdata", v1 ? e1 : 32'h0, rdata);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req <= '{wr: w, rd: r, addr: a, wdata: d};
    ev <= r;
    ed <= d;
  endtask : op
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (1000) @(posedge sys_clk);
    n_errors++;
    close_out();
  end
  initial
  begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int a = 0; a < 196; a += 4) op(1'b0, 1'b1, 8'(a), 32'h0);
    op(1'b1, 1'b0, 8'h44, 32'hffff_ffff);
    op(1'b0, 1'b1, 8'h44, 32'h0000_000f);
    op(1'b1, 1'b0, 8'h80, 32'hffff_ffff);
    op(1'b0, 1'b1, 8'h80, 32'h0000_a000);
    op(1'b1, 1'b0, 8'h00, 32'h0000_0005);
    op(1'b0, 1'b1, 8'h00, 32'h0000_0005);
    op(1'b1, 1'b0, 8'hc0, 32'h0000_2000);
    op(1'b0, 1'b1, 8'h00, 32'h0000_0005);
    @(negedge sys_clk);
    chk("remap_lock", 32'h1, 32'(remap_lock));
    op(1'b1, 1'b0, 8'h00, 32'h0000_000a);
    op(1'b0, 1'b1, 8'h00, 32'h0000_0005);
    op(1'b0, 1'b1, 8'hc0, 32'h0000_2000);
    op(1'b1, 1'b0, 8'hc0, 32'h0);
    op(1'b1, 1'b0, 8'h40, 32'h0000_0002);
    @(negedge sys_clk);
    chk("remap_lock", 32'h0, 32'(remap_lock));
    op(1'b0, 1'b0, 8'h00, 32'h0);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("pin_out", 32'h1, 32'(pin_out[0]));
    chk("periph_in", 32'h1, 32'(periph_in[0]));
    chk("cn", 32'h3, 32'(cn_active[0]));
    @(posedge sys_clk);
    idle_mode <= 1'b1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("cn", 32'h1, 32'(cn_active[0]));
    op(1'b1, 1'b0, 8'h80, 32'h0000_8000);
    op(1'b0, 1'b0, 8'h00, 32'h0);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("cn", 32'h2, 32'(cn_active[0]));
    close_out();
  end
endmodule : pprc_remap_bench
`default_nettype wire

// ==== test/pprc_remap_props.sv ====
/* Assertions on the pprc_remap ports.
   Assumes the identity lookup tables and one clock. */
`timescale 1ns/1ps
`default_nettype none
module pprc_remap_props
  import pprc_pkg::*;
(
  input wire logic                  sys_clk,
  input wire logic                  resetn,
  input wire pprc_req_t             req,
  input wire logic [31:0]           rdata,
  input wire logic                  idle_mode,
  input wire logic [15:0]           periph_out,
  input wire logic [N_OUT-1:0]      pin_out,
  input wire pprc_cn_t [N_PORT-1:0] cn_active,
  input wire logic                  remap_lock
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_in_sel_rw: assert property (req.wr && !remap_lock && req.addr == 8'h00
    ##1 req.rd && req.addr == 8'h00 |=> rdata[3:0] == $past(req.wdata[3:0], 2)) else $error("in sel");
  a_out_sel_rw: assert property (req.wr && !remap_lock && req.addr == 8'h44
    ##1 req.rd && req.addr == 8'h44 |=> rdata[3:0] == $past(req.wdata[3:0], 2)) else $error("out sel");
  a_sel_high_zero: assert property ($past(req.rd) && $past(req.addr) < 8'h80
    |-> rdata[31:4] == 28'h0) else $error("sel high bits");
  a_lock_hold: assert property (req.rd && req.addr == 8'h00 ##1 req.wr && remap_lock &&
    req.addr == 8'h00 ##1 req.rd && req.addr == 8'h00 |=> rdata == $past(rdata, 2)) else $error("lock");
  a_cn_enable: assert property (req.wr && req.addr == 8'h80 && !idle_mode ##1 !idle_mode
    |=> cn_active[0].on == $past(req.wdata[15], 2)) else $error("cn on");
  a_idle_halt: assert property (idle_mode && cn_active[0].idle_stop && !$past(req.wr)
    |=> !cn_active[0].on) else $error("idle stop");
  a_cn_rsvd: assert property ($past(req.rd) && $past(req.addr) == 8'h80
    |-> (rdata & 32'hffff_5fff) == 32'h0) else $error("cn reserved");
  a_out_route: assert property (req.wr && req.addr == 8'h40 && !remap_lock
    ##1 $stable(periph_out) |=> pin_out[0] == $past(periph_out[req.wdata[3:0]], 2)) else $error("route");
endmodule : pprc_remap_props
bind pprc_remap pprc_remap_props u_props (.sys_clk(sys_clk), .resetn(resetn), .req(req),
  .rdata(rdata), .idle_mode(idle_mode), .periph_out(periph_out), .pin_out(pin_out),
  .cn_active(cn_active), .remap_lock(remap_lock));
`default_nettype wire
